// ---- src/t1c_pkg.sv ----
/*
 Constants, register map and mode type for the 16-bit timer/counter.
 Assumes a 32-bit AHB-Lite register port with one register per word.
*/
package t1c_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] LOW_OFS    = 8'h04;
	localparam logic [7:0] HIGH_OFS   = 8'h08;
	localparam logic [7:0] IRQ_OFS    = 8'h0C;
	// Control register fields
	localparam int         WIDE_BIT   = 7;
	localparam int         SYSCLK_BIT = 6;
	localparam int         PS_HI      = 5;
	localparam int         PS_LO      = 4;
	localparam int         OSC_BIT    = 3;
	localparam int         SYNC_BIT   = 2;
	localparam int         CS_BIT     = 1;
	localparam int         RUN_BIT    = 0;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hBF;
	// Overflow register fields
	localparam int         FLAG_BIT   = 0;
	localparam int         IE_BIT     = 1;
	// Instruction clock is the system clock divided by four
	localparam logic [1:0] INSTR_LAST = 2'h3;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [2:0]  PRE_ONE   = 3'h1;

	typedef enum logic [2:0]
	{
		T1C_MODE_TIMER = 3'b001,
		T1C_MODE_SYNC  = 3'b010,
		T1C_MODE_ASYNC = 3'b100
	} t1c_mode_t;

	// Prescale code to the mask of counter bits that must all be set
	function automatic logic [2:0] prescale_mask(input logic [1:0] code);
		unique case (code)
			2'h0: prescale_mask = 3'h0;
			2'h1: prescale_mask = 3'h1;
			2'h2: prescale_mask = 3'h3;
			2'h3: prescale_mask = 3'h7;
		endcase
	endfunction
endpackage

// ---- src/t1c_sync_edge.sv ----
/*
 Two-stage synchroniser for one pin with edge detection behind it.
 Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/10ps
module t1c_sync_edge
(
	input  wire logic clk,   // System clock
	input  wire logic rst,   // Synchronous reset, active high
	input  wire logic pin,   // Raw asynchronous pin
	output logic      level, // Synchronised level
	output logic      rise,  // One-cycle pulse on rising edge
	output logic      fall   // One-cycle pulse on falling edge
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;
endmodule

// ---- src/t1c_timer.sv ----
/*
 16-bit timer/counter with prescaler, crystal oscillator pin control,
 buffered 16-bit access and overflow flag, behind an AHB-Lite slave.
 Assumes a single bus master, whole-word transfers and pins asynchronous to clk.
*/
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
module t1c_timer
(
	input  wire logic        clk,                 // System clock, 250 MHz
	input  wire logic        rst,                 // Synchronous reset, active high
	input  wire logic        hsel,                // AHB slave select
	input  wire logic [31:0] haddr,               // AHB address
	input  wire logic [1:0]  htrans,              // AHB transfer type
	input  wire logic        hwrite,              // AHB write
	input  wire logic [2:0]  hsize,               // AHB size, word only
	input  wire logic        hready,              // AHB bus ready
	input  wire logic [31:0] hwdata,              // AHB write data
	output logic      [31:0] hrdata,              // AHB read data
	output logic             hreadyout,           // AHB slave ready
	output logic             hresp,               // AHB response, always OKAY
	input  wire logic        sysclk_is_timer_osc, // Clock switch reports timer oscillator
	input  wire logic        ext_count_clock_in,  // Pad 0: count clock / oscillator output
	input  wire logic        osc_input_pin,       // Pad 1: oscillator input
	input  wire logic [1:0]  port_c_direction,    // Port direction, 1 = input
	input  wire logic [1:0]  port_c_out,          // Port output data
	output logic      [1:0]  pin_c_out,           // Pad output levels
	output logic      [1:0]  pin_c_oe,            // Pad output enables
	output logic      [1:0]  port_c_read,         // Pad levels seen by the port
	output logic             overflow_irq         // Overflow flag and enable
);
	logic [7:0]  ctrl_q;
	logic        flag_q;
	logic        ie_q;
	logic [15:0] count_q;
	logic [7:0]  buf_q;
	logic [2:0]  presc_q;
	logic [1:0]  div_q;
	logic        armed_q;
	logic        sync_pend_q;
	logic        run_prev_q;
	logic        hi_at_stop_q;
	logic        wr_pend_q;
	logic        rd_pend_q;
	logic [7:0]  addr_q;
	logic [31:0] hrdata_q;
	logic        hreadyout_q;
	logic        hresp_q;
	logic [1:0]  pin_out_q;
	logic [1:0]  pin_oe_q;
	logic [1:0]  port_read_q;
	logic        irq_q;
	logic        ext_lvl;
	logic        ext_rise;
	logic        ext_fall;
	logic        osc_lvl;
	logic        wide;
	logic        run;
	logic        osc_en;
	logic        accept;
	logic        wr_low;
	logic        wr_high;
	logic        rd_low;
	logic        instr_tick;
	logic        src_tick;
	logic        inc;
	logic        ovf;
	logic        flag_d;
	logic [31:0] rd_val;
	t1c_pkg::t1c_mode_t mode;

	t1c_sync_edge u_ext
	(
		.clk   (clk),
		.rst   (rst),
		.pin   (ext_count_clock_in),
		.level (ext_lvl),
		.rise  (ext_rise),
		.fall  (ext_fall)
	);

	t1c_sync_edge u_osc
	(
		.clk   (clk),
		.rst   (rst),
		.pin   (osc_input_pin),
		.level (osc_lvl),
		.rise  (),
		.fall  ()
	);

	assign wide   = ctrl_q[t1c_pkg::WIDE_BIT];
	assign run    = ctrl_q[t1c_pkg::RUN_BIT];
	assign osc_en = ctrl_q[t1c_pkg::OSC_BIT];

	// Bus decode
	assign accept  = hsel & hready & htrans[1];
	assign wr_low  = wr_pend_q & (addr_q == t1c_pkg::LOW_OFS);
	assign wr_high = wr_pend_q & (addr_q == t1c_pkg::HIGH_OFS);
	assign rd_low  = rd_pend_q & (addr_q == t1c_pkg::LOW_OFS);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_pend_q   <= 1'b0;
			rd_pend_q   <= 1'b0;
			addr_q      <= 8'h00;
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
		end
		else
		begin
			wr_pend_q   <= accept & hwrite;
			rd_pend_q   <= accept & ~hwrite;
			// One wait state on reads so a prior write is visible
			hreadyout_q <= ~(accept & ~hwrite);
			if (accept)
				addr_q <= haddr[7:0];
		end
	end

	always_comb
	begin
		rd_val = 32'h0000_0000;
		unique case (addr_q)
			t1c_pkg::CTRL_OFS: rd_val[7:0] = ctrl_q;
			t1c_pkg::LOW_OFS:  rd_val[7:0] = count_q[7:0];
			t1c_pkg::HIGH_OFS: rd_val[7:0] = wide ? buf_q : count_q[15:8];
			t1c_pkg::IRQ_OFS:
			begin
				rd_val[t1c_pkg::FLAG_BIT] = flag_q;
				rd_val[t1c_pkg::IE_BIT]   = ie_q;
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			hrdata_q <= 32'h0000_0000;
		else if (rd_pend_q)
			hrdata_q <= rd_val;
	end

	// Control register; status bit follows the clock switch
	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl_q <= t1c_pkg::CTRL_RST;
		else
		begin
			if (wr_pend_q && addr_q == t1c_pkg::CTRL_OFS)
				ctrl_q <= hwdata[7:0] & t1c_pkg::CTRL_WMASK;
			ctrl_q[t1c_pkg::SYSCLK_BIT] <= sysclk_is_timer_osc;
		end
	end

	// Mode decode
	always_comb
	begin
		if (!ctrl_q[t1c_pkg::CS_BIT])
			mode = t1c_pkg::T1C_MODE_TIMER;
		else if (ctrl_q[t1c_pkg::SYNC_BIT])
			mode = t1c_pkg::T1C_MODE_ASYNC;
		else
			mode = t1c_pkg::T1C_MODE_SYNC;
	end

	// Instruction clock enable
	always_ff @(posedge clk)
	begin
		if (rst)
			div_q <= 2'h0;
		else
			div_q <= div_q + 2'h1;
	end
	assign instr_tick = (div_q == t1c_pkg::INSTR_LAST);

	// Falling-edge arming for counter mode
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			armed_q      <= 1'b0;
			run_prev_q   <= 1'b0;
			hi_at_stop_q <= 1'b0;
		end
		else
		begin
			run_prev_q <= run;
			if (run_prev_q && !run)
				hi_at_stop_q <= ext_lvl;
			if (wr_low || wr_high)
				armed_q <= 1'b0;
			else if (run && !run_prev_q && hi_at_stop_q && !ext_lvl)
				armed_q <= 1'b0;
			else if (run && ext_fall)
				armed_q <= 1'b1;
		end
	end

	// Synchronous counting waits for the next instruction cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			sync_pend_q <= 1'b0;
		else if (mode != t1c_pkg::T1C_MODE_SYNC)
			sync_pend_q <= 1'b0;
		else if (ext_rise && armed_q)
			sync_pend_q <= 1'b1;
		else if (instr_tick)
			sync_pend_q <= 1'b0;
	end

	always_comb
	begin
		unique case (mode)
			t1c_pkg::T1C_MODE_TIMER: src_tick = instr_tick;
			t1c_pkg::T1C_MODE_SYNC:  src_tick = sync_pend_q & instr_tick;
			t1c_pkg::T1C_MODE_ASYNC: src_tick = ext_rise & armed_q;
			default:                 src_tick = 1'b0;
		endcase
	end

	// Prescaler and count
	assign inc = run & src_tick
		& ((presc_q & t1c_pkg::prescale_mask(ctrl_q[t1c_pkg::PS_HI:t1c_pkg::PS_LO]))
		== t1c_pkg::prescale_mask(ctrl_q[t1c_pkg::PS_HI:t1c_pkg::PS_LO]));
	assign ovf = inc & (count_q == t1c_pkg::COUNT_MAX) & ~wr_low & ~wr_high;

	always_ff @(posedge clk)
	begin
		if (rst)
			presc_q <= 3'h0;
		else if (wr_low || (wr_high && !wide))
			presc_q <= 3'h0;
		else if (run && src_tick)
			presc_q <= presc_q + t1c_pkg::PRE_ONE;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			count_q <= 16'h0000;
		else if (wr_low)
			count_q <= wide ? {buf_q, hwdata[7:0]} : {count_q[15:8], hwdata[7:0]};
		else if (wr_high && !wide)
			count_q[15:8] <= hwdata[7:0];
		else if (inc)
			count_q <= count_q + t1c_pkg::COUNT_ONE;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			buf_q <= 8'h00;
		else if (wr_high && wide)
			buf_q <= hwdata[7:0];
		else if (rd_low && wide)
			buf_q <= count_q[15:8];
	end

	// Overflow flag: write 1 clears, a new overflow wins
	always_comb
	begin
		flag_d = flag_q;
		if (wr_pend_q && addr_q == t1c_pkg::IRQ_OFS && hwdata[t1c_pkg::FLAG_BIT])
			flag_d = 1'b0;
		if (ovf)
			flag_d = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			flag_q <= 1'b0;
			ie_q   <= 1'b0;
			irq_q  <= 1'b0;
		end
		else
		begin
			flag_q <= flag_d;
			if (wr_pend_q && addr_q == t1c_pkg::IRQ_OFS)
				ie_q <= hwdata[t1c_pkg::IE_BIT];
			irq_q <= flag_d & ie_q;
		end
	end

	// Pads: oscillator inverter replaces the port logic when enabled
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_out_q   <= 2'h0;
			pin_oe_q    <= 2'h0;
			port_read_q <= 2'h0;
		end
		else if (osc_en)
		begin
			pin_out_q   <= {1'b0, ~osc_lvl};
			pin_oe_q    <= 2'h1;
			port_read_q <= 2'h0;
		end
		else
		begin
			pin_out_q   <= port_c_out;
			pin_oe_q    <= ~port_c_direction;
			port_read_q <= {osc_lvl, ext_lvl};
		end
	end

	assign hrdata       = hrdata_q;
	assign hreadyout    = hreadyout_q;
	assign hresp        = hresp_q;
	assign pin_c_out    = pin_out_q;
	assign pin_c_oe     = pin_oe_q;
	assign port_c_read  = port_read_q;
	assign overflow_irq = irq_q;

	read_wait_a: assert property (@(posedge clk) disable iff (rst)
		accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	okay_resp_a: assert property (@(posedge clk) disable iff (rst) !hresp)
		else $error("response not OKAY");
	sysclk_stat_a: assert property (@(posedge clk) disable iff (rst)
		##1 ctrl_q[t1c_pkg::SYSCLK_BIT] == $past(sysclk_is_timer_osc))
		else $error("clock status bit wrong");
	stop_hold_a: assert property (@(posedge clk) disable iff (rst)
		!run && !wr_low && !wr_high |=> count_q == $past(count_q))
		else $error("count moved while stopped");
	ovf_flag_a: assert property (@(posedge clk) disable iff (rst)
		ovf |=> flag_q && count_q == 16'h0000)
		else $error("overflow not flagged");
	osc_pins_a: assert property (@(posedge clk) disable iff (rst)
		osc_en [*2] |-> port_c_read == 2'h0 && pin_c_oe == 2'h1)
		else $error("pins not disabled by oscillator");
	disarm_a: assert property (@(posedge clk) disable iff (rst)
		wr_low |=> !armed_q)
		else $error("count write did not disarm");
	wide_buf_a: assert property (@(posedge clk) disable iff (rst)
		rd_low && wide |=> buf_q == $past(count_q[15:8]))
		else $error("buffer not loaded on low read");
	div8_a: assert property (@(posedge clk) disable iff (rst)
		inc && ctrl_q[t1c_pkg::PS_HI:t1c_pkg::PS_LO] == 2'h3 |-> presc_q == 3'h7)
		else $error("divide by eight wrong");
	timer_rate_a: assert property (@(posedge clk) disable iff (rst)
		inc && mode == t1c_pkg::T1C_MODE_TIMER |-> instr_tick)
		else $error("timer count off instruction clock");
endmodule

// ---- bench/t1c_ext_src.sv ----
/*
 Far-side model: count clock source on pad 0 and crystal on pad 1.
 Assumes the bench resolves each pad from the design's output enables.
*/
`timescale 1ns/10ps
module t1c_ext_src
(
	input  wire logic xtal_on, // Crystal running
	output logic      clk_drv, // Pad 0 drive
	output logic      osc_drv  // Pad 1 drive
);
	initial
	begin
		clk_drv = 1'h0;
		osc_drv = 1'h0;
	end

	// Count clock stands low between bursts
	task automatic burst(input int n);
		// Keep pad edges off the sampling edge of clk
		#1;
		repeat (n)
		begin
			#20 clk_drv = 1'h1;
			#20 clk_drv = 1'h0;
		end
	endtask

	// Crystal swings only while enabled
	always #7 osc_drv = xtal_on ? ~osc_drv : osc_drv;
endmodule

// ---- bench/testbench.sv ----
/*
 Self-checking bench: AHB-Lite master, pad resolution and a read monitor.
 Assumes one wait state on reads and zero on writes.
*/
`timescale 1ns/10ps
module testbench;
	logic        clk, hwrite, hresp, hreadyout, overflow_irq, clk_drv, osc_drv;
	logic        rst = 1'h1, hsel = 1'h0, rd_ph = 1'h0, xtal_on = 1'h0;
	logic        sysclk_is_timer_osc = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h5C77, hrdata;
	logic [1:0]  htrans = 2'h0, port_c_direction = 2'h3, port_c_out = 2'h0;
	logic [1:0]  pin_c_out, pin_c_oe, port_c_read;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] exq[$];
	int          tq[$];
	int          err_total = 0, checked = 0;
	wire         pad0 = pin_c_oe[0] ? pin_c_out[0] : clk_drv;
	wire         pad1 = pin_c_oe[1] ? pin_c_out[1] : osc_drv;

	t1c_timer uut
	(
		.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sysclk_is_timer_osc(sysclk_is_timer_osc), .ext_count_clock_in(pad0),
		.osc_input_pin(pad1), .port_c_direction(port_c_direction),
		.port_c_out(port_c_out), .pin_c_out(pin_c_out), .pin_c_oe(pin_c_oe),
		.port_c_read(port_c_read), .overflow_irq(overflow_irq)
	);

	t1c_ext_src ext
	(
		.xtal_on(xtal_on), .clk_drv(clk_drv), .osc_drv(osc_drv)
	);

	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s, input int t);
		checked++;
		if ($isunknown(s) || s < e - t || s > e + t)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic end_sim;
		if (exq.size() != 0)
		begin
			err_total++;
			$display("[ERR] pending_reads expected 0 seen %0d", exq.size());
		end
		$display("Checks %0d, errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Single word transfer; a read leaves its expectation in the queue
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input int t);
		int n;
		n = 0;
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hreadyout !== 1'h1 && n < 20);
		if (hreadyout !== 1'h1)
		begin
			err_total++;
			$display("[ERR] hreadyout expected 1 seen %b", hreadyout);
			end_sim;
		end
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= ~w;
		if (!w)
		begin
			exq.push_back(e);
			tq.push_back(t);
		end
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hreadyout !== 1'h1 && n < 40);
		rd_ph <= 1'h0;
		if (hreadyout !== 1'h1)
		begin
			err_total++;
			$display("[ERR] hreadyout expected 1 seen %b", hreadyout);
			end_sim;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d, 32'h0, 0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input int t);
		bus(1'h0, a, 32'h0, e, t);
	endtask

	// Read data is taken at the edge that ends the data phase
	always @(posedge clk)
		if (rd_ph && hreadyout === 1'h1 && exq.size() > 0)
		begin
			chk("hrdata", exq.pop_front(), hrdata, tq.pop_front());
			chk("hresp", 32'h0, {31'h0, hresp}, 0);
		end

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		for (int a = 0; a < 20; a += 4)
			rd(a[7:0], 32'h0, 0);
		wr(8'h10, 32'hFF);
		rd(8'h10, 32'h0, 0);
		wr(8'h00, 32'hFF);
		rd(8'h00, 32'hBF, 0);
		sysclk_is_timer_osc <= 1'h1;
		rd(8'h00, 32'hFF, 0);
		sysclk_is_timer_osc <= 1'h0;
		wr(8'h00, 32'h0);
		seed = lfsr(seed);
		port_c_out <= seed[1:0];
		port_c_direction <= 2'h0;
		repeat (4) @(posedge clk);
		chk("pin_oe", 32'h3, {30'h0, pin_c_oe}, 0);
		chk("pin_out", {30'h0, seed[1:0]}, {30'h0, pin_c_out}, 0);
		port_c_direction <= 2'h3;
		repeat (6) @(posedge clk);
		chk("port_rd", {30'h0, pad1, pad0}, {30'h0, port_c_read}, 0);
		xtal_on <= 1'h1;
		wr(8'h00, 32'h8);
		port_c_direction <= 2'h0;
		repeat (6) @(posedge clk);
		chk("port_rd", 32'h0, {30'h0, port_c_read}, 0);
		chk("osc_in_oe", 32'h0, {31'h0, pin_c_oe[1]}, 0);
		chk("osc_out_oe", 32'h1, {31'h0, pin_c_oe[0]}, 0);
		wr(8'h00, 32'h0);
		xtal_on <= 1'h0;
		port_c_direction <= 2'h3;
		// Sync bit toggles too: internal source must ignore it
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h04, 32'h0);
			wr(8'h00, {26'h0, c[1:0], 1'h0, c[0], 2'h1});
			repeat (64 << c) @(posedge clk);
			wr(8'h00, 32'h0);
			rd(8'h04, 32'h10, 1);
		end
		// First rising edge after a count write is not counted
		for (int s = 0; s < 2; s++)
		begin
			wr(8'h00, 32'h0);
			wr(8'h04, 32'h0);
			wr(8'h00, {29'h0, s[0], 2'h3});
			ext.burst(5);
			repeat (8) @(posedge clk);
			rd(8'h04, 32'h4, 0);
		end
		wr(8'h00, 32'h2);
		ext.burst(3);
		repeat (8) @(posedge clk);
		rd(8'h04, 32'h4, 0);
		// Stop with the count pin high, start with it low: first rise is lost
		port_c_out <= 2'h1;
		port_c_direction <= 2'h2;
		repeat (8) @(posedge clk);
		wr(8'h00, 32'h3);
		wr(8'h00, 32'h2);
		port_c_direction <= 2'h3;
		repeat (8) @(posedge clk);
		wr(8'h00, 32'h3);
		ext.burst(3);
		repeat (8) @(posedge clk);
		wr(8'h00, 32'h2);
		rd(8'h04, 32'h6, 0);
		wr(8'h08, 32'hFF);
		wr(8'h04, 32'hFE);
		wr(8'h0C, 32'h2);
		wr(8'h00, 32'h1);
		repeat (12) @(posedge clk);
		wr(8'h00, 32'h0);
		rd(8'h0C, 32'h3, 0);
		chk("irq", 32'h1, {31'h0, overflow_irq}, 0);
		rd(8'h08, 32'h0, 0);
		wr(8'h0C, 32'h0);
		rd(8'h0C, 32'h1, 0);
		chk("irq", 32'h0, {31'h0, overflow_irq}, 0);
		wr(8'h0C, 32'h1);
		rd(8'h0C, 32'h0, 0);
		seed = lfsr(seed);
		wr(8'h00, 32'h80);
		wr(8'h08, {24'h0, seed[7:0]});
		wr(8'h04, {24'h0, seed[15:8]});
		wr(8'h08, {24'h0, ~seed[7:0]});
		rd(8'h04, {24'h0, seed[15:8]}, 0);
		rd(8'h08, {24'h0, seed[7:0]}, 0);
		wr(8'h00, 32'h0);
		rd(8'h08, {24'h0, seed[7:0]}, 0);
		rd(8'h04, {24'h0, seed[15:8]}, 0);
		repeat (4) @(posedge clk);
		end_sim;
	end
endmodule
